/* design/hardware_option_loader.sv */
// option loader: options, boot select, watchdog presets, debug
// assumes apb master on clk; options kept in flops
//
// Overview of operation
// - erase clears all options and the flash
// - locked code reads back as ff
// - boot region runs from start to 1fff
// - power-up boot follows power-up select
// - any-reset select boots region on debug reset only
// - field region set by option or software
// - three bits pick secondary brown-out threshold
// - primary brown-out resets to main start
// - secondary brown-out resets to main start
// - option presets watchdog reset enable
// - option presets watchdog non-stop bit
// - auto-start loads watchdog control at power-on
// - write protect blocks watchdog writes except the enable bit
// - debug owns p4.4/p4.5 after power-on
// - debug enable bit returns pins
// - programming only while device halted
// - programming path writes flash and options
// - reset run stop step cursor supported
// - up to four breakpoints, each with its own arm bit
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "opt_loader_consts.svh"
module hardware_option_loader #(
   parameter int BREAKS = 4,
   parameter int FLASH_WORDS = 16
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        power_on,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        adapter_reset,
   input  wire logic        primary_brownout_detector,
   input  wire logic        secondary_brownout_detector,
   input  wire logic        watchdog_timeout_flag,
   input  wire logic [15:0] cpu_pc,
   input  wire logic        pin44_in,
   input  wire logic        pin45_in,
   input  wire logic        port44_out,
   input  wire logic        port44_oe,
   input  wire logic        port45_out,
   input  wire logic        port45_oe,
   output logic             pin44_out,
   output logic             pin44_oe,
   output logic             pin45_out,
   output logic             pin45_oe,
   output logic             port44_in,
   output logic             port45_in,
   output logic             cpu_reset,
   output logic             cpu_halt,
   output logic [15:0]      boot_address,
   output logic [15:0]      boot_region_start,
   output logic             boot_region_valid,
   output logic [2:0]       brownout2_threshold,
   output logic [7:0]       watchdog_control_register,
   output logic [7:0]       field_data_lower_boundary
);
   initial begin
      if (BREAKS < 1 || BREAKS > 4) $error("BREAKS must be 1..4");
      if (FLASH_WORDS < 2 || FLASH_WORDS > 256) $error("FLASH_WORDS must be 2..256");
   end

   localparam int FW = $clog2(FLASH_WORDS);

   typedef struct packed {
      opt_loader_pkg::load_state_t ld;
      logic [`OPT_WIDTH-1:0]       opt;
      logic [7:0]                  wdt;
      logic                        debug_en;
      logic [7:0]                  field_bound;
      logic [15:0]                 boot;
      logic                        cold;
      logic                        halt;
      logic                        stepping;
      logic                        cursor_arm;
      logic [15:0]                 cursor;
      logic [15:0]                 prog_addr;
      logic [31:0]                 rdata;
      logic [2:0]                  rst_s1;
      logic [2:0]                  rst_s2;
      logic                        hold_reset;
      logic [BREAKS*17-1:0]        brk;
      logic [FLASH_WORDS*8-1:0]    flash;
   } loader_state_t;

   loader_state_t st;
   loader_state_t next_st;
   pin_mux_if     mux_bus();

   // ****
   // decoding helpers
   // ****
   // region start from size code; 0 means none
   function automatic logic [15:0] region_start(input logic [2:0] code);
      logic [15:0] s;
      s = 16'h0000;
      unique case (code)
         3'h1: s = 16'h1e00;
         3'h2: s = 16'h1c00;
         3'h3: s = 16'h1a00;
         3'h4: s = 16'h1800;
         3'h5: s = 16'h1600;
         3'h6: s = 16'h1400;
         3'h7: s = 16'h1200;
         3'h0: s = 16'h0000;
      endcase
      return s;
   endfunction

   // brown-out or watchdog reset causes
   function automatic logic warm_cause(input logic [`OPT_WIDTH-1:0] o, input logic b1,
                                       input logic b2, input logic wf, input logic [7:0] w);
      return (o[`OPT_BO1_RESET] & b1) | (o[`OPT_BO2_RESET] & b2) | (w[`WDT_RESET_EN] & wf);
   endfunction

   logic [2:0]  boot_code;
   logic        region_ok;
   logic        warm;
   logic        hit;
   logic        apb_wr;
   logic        apb_rd;
   logic [FW-1:0] fidx;

   assign boot_code = st.opt[`OPT_BOOT_HI:`OPT_BOOT_LO];
   assign region_ok = (boot_code != 3'h0);
   assign warm      = warm_cause(st.opt, st.rst_s2[0], st.rst_s2[1], watchdog_timeout_flag,
                                 st.wdt);
   assign apb_wr    = psel & penable & pwrite;
   assign apb_rd    = psel & penable & ~pwrite;
   assign fidx      = st.prog_addr[FW-1:0];

   // compare all armed breakpoints
   always_comb begin
      hit = 1'b0;
      for (int i = 0; i < BREAKS; i++) begin
         if (st.brk[i*17+16] && st.brk[i*17 +: 16] == cpu_pc) begin
            hit = 1'b1;
         end
      end
   end

   // ****
   // next state
   // ****
   always_comb begin
      next_st            = st;
      // adapter reset is a pin too, so it is synchronised with the detectors
      next_st.rst_s1     = {adapter_reset, secondary_brownout_detector,
                            primary_brownout_detector};
      next_st.rst_s2     = st.rst_s1;
      next_st.hold_reset = 1'b0;
      next_st.stepping   = 1'b0;

      unique case (st.ld)
         opt_loader_pkg::ld_idle: begin
            next_st.ld = opt_loader_pkg::ld_load;
         end
         opt_loader_pkg::ld_load: begin
            // apply options before the core leaves reset
            next_st.field_bound = st.opt[`OPT_FIELD_HI:`OPT_FIELD_LO];
            if (st.cold) begin
               if (st.opt[`OPT_WDT_AUTOSTART]) begin
                  next_st.wdt = {1'b1, st.opt[`OPT_WDT_RESET], st.opt[`OPT_WDT_NONSTOP],
                                 st.opt[`OPT_WDT_IDLE], 1'b0,
                                 st.opt[`OPT_WDT_PS_HI:`OPT_WDT_PS_LO]};
               end else begin
                  next_st.wdt = {1'b0, st.opt[`OPT_WDT_RESET], st.opt[`OPT_WDT_NONSTOP],
                                 5'h00};
               end
               next_st.boot = (st.opt[`OPT_PWRUP_BOOT] && region_ok) ?
                              region_start(boot_code) : `MAIN_START;
            end else if (st.opt[`OPT_ANYRST_BOOT] && region_ok) begin
               next_st.boot = region_start(boot_code);
            end
            next_st.cold = 1'b0;
            next_st.ld   = opt_loader_pkg::ld_run;
         end
         opt_loader_pkg::ld_run: begin
            if (warm) begin
               // restart at main start
               next_st.boot       = `MAIN_START;
               next_st.hold_reset = 1'b1;
            end
         end
      endcase

      // adapter reset halts the core
      if (st.rst_s2[2]) begin
         next_st.halt = 1'b1;
      end

      if (st.halt && st.cursor_arm && hit) begin
         next_st.halt = 1'b1;
      end
      if (!st.halt && (hit || (st.cursor_arm && cpu_pc == st.cursor))) begin
         next_st.halt       = 1'b1;
         next_st.cursor_arm = 1'b0;
      end
      if (st.stepping) begin
         next_st.halt = 1'b1;
      end

      // apb writes on the access edge
      if (apb_wr) begin
         unique case (paddr)
            `OFS_OPTION: begin
               if (st.halt) begin
                  next_st.opt = pwdata[`OPT_WIDTH-1:0];
               end
            end
            `OFS_STATUS: begin
               if (st.halt && pwdata[0]) begin
                  // whole-chip erase
                  next_st.opt   = `OPT_ERASED;
                  next_st.flash = '1;
               end
            end
            `OFS_WDT_CTRL: begin
               next_st.wdt[`WDT_ENABLE] = pwdata[`WDT_ENABLE];
               if (!st.opt[`OPT_WDT_WPROT]) begin
                  next_st.wdt[6:0] = pwdata[6:0];
               end
            end
            `OFS_DEBUG_CTRL: next_st.debug_en = pwdata[0];
            `OFS_FIELD_BOUND: next_st.field_bound = pwdata[7:0];
            `OFS_PROG_ADDR: next_st.prog_addr = pwdata[15:0];
            `OFS_PROG_DATA: begin
               if (st.halt) begin
                  next_st.flash[fidx*8 +: 8] = pwdata[7:0];
               end
            end
            `OFS_DEBUG_CMD: begin
               unique case (opt_loader_pkg::debug_cmd_t'(pwdata[2:0]))
                  opt_loader_pkg::dbg_reset: begin
                     next_st.ld   = opt_loader_pkg::ld_idle;
                     next_st.halt = 1'b1;
                  end
                  opt_loader_pkg::dbg_run: next_st.halt = 1'b0;
                  opt_loader_pkg::dbg_stop: next_st.halt = 1'b1;
                  opt_loader_pkg::dbg_step: begin
                     next_st.halt     = 1'b0;
                     next_st.stepping = 1'b1;
                  end
                  opt_loader_pkg::dbg_cursor: begin
                     next_st.cursor     = pwdata[31:16];
                     next_st.cursor_arm = 1'b1;
                     next_st.halt       = 1'b0;
                  end
                  default: next_st.halt = st.halt;
               endcase
            end
            default: begin
               for (int i = 0; i < BREAKS; i++) begin
                  if (paddr == `OFS_BREAK_BASE + 12'(i * 4)) begin
                     next_st.brk[i*17 +: 17] = pwdata[16:0];
                  end
               end
            end
         endcase
      end

      // read data registered in setup
      next_st.rdata = 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
         unique case (paddr)
            `OFS_OPTION: next_st.rdata = {5'h00, st.opt};
            `OFS_STATUS: next_st.rdata = {16'h0000, st.boot};
            `OFS_WDT_CTRL: next_st.rdata = {24'h000000, st.wdt};
            `OFS_DEBUG_CTRL: next_st.rdata = {31'h0, st.debug_en};
            `OFS_FIELD_BOUND: next_st.rdata = {24'h000000, st.field_bound};
            `OFS_PROG_ADDR: next_st.rdata = {16'h0000, st.prog_addr};
            `OFS_PROG_DATA: next_st.rdata = {24'h000000, st.opt[`OPT_LOCK] ?
                                             `LOCKED_BYTE : st.flash[fidx*8 +: 8]};
            `OFS_DEBUG_CMD: next_st.rdata = {30'h0, st.cursor_arm, st.halt};
            default: begin
               for (int i = 0; i < BREAKS; i++) begin
                  if (paddr == `OFS_BREAK_BASE + 12'(i * 4)) begin
                     next_st.rdata = {15'h0000, st.brk[i*17 +: 17]};
                  end
               end
            end
         endcase
      end
   end

   // ****
   // state register
   // ****
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st          <= '0;
         st.ld       <= opt_loader_pkg::ld_idle;
         st.debug_en <= 1'b1;
         st.cold     <= 1'b1;
      end else if (power_on) begin
         // a new power-on reloads presets; stored options stay
         st.ld       <= opt_loader_pkg::ld_idle;
         st.cold     <= 1'b1;
         st.debug_en <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign mux_bus.debug_enable = st.debug_en;
   assign mux_bus.halted       = st.halt;

   debug_pin_mux u_mux (
      .clk        (clk),
      .rst        (rst),
      .bus        (mux_bus.mux),
      .pin44_in   (pin44_in),
      .pin45_in   (pin45_in),
      .port44_out (port44_out),
      .port44_oe  (port44_oe),
      .port45_out (port45_out),
      .port45_oe  (port45_oe),
      .pin44_out  (pin44_out),
      .pin44_oe   (pin44_oe),
      .pin45_out  (pin45_out),
      .pin45_oe   (pin45_oe),
      .port44_in  (port44_in),
      .port45_in  (port45_in)
   );

   // ****
   // outputs
   // ****
   // core held in reset until options applied
   assign cpu_reset                 = (st.ld != opt_loader_pkg::ld_run) | st.hold_reset;
   assign cpu_halt                  = st.halt;
   assign boot_address              = st.boot;
   assign boot_region_start         = region_start(boot_code);
   assign boot_region_valid         = region_ok;
   assign brownout2_threshold       = st.opt[`OPT_BO2_SEL_HI:`OPT_BO2_SEL_LO];
   assign watchdog_control_register = st.wdt;
   assign field_data_lower_boundary = st.field_bound;
   assign prdata                    = st.rdata;
   assign pready                    = 1'b1;
   assign pslverr                   = 1'b0;
endmodule

/* design/opt_loader_consts.svh */
// loader constants: apb offsets, option fields, resets
// assumes inclusion by the design files and the test bench
`ifndef OPT_LOADER_CONSTS_SVH
`define OPT_LOADER_CONSTS_SVH

// ****
// register map (byte addresses)
// ****
`define OFS_OPTION         12'h000
`define OFS_STATUS         12'h004
`define OFS_WDT_CTRL       12'h008
`define OFS_DEBUG_CTRL     12'h00c
`define OFS_FIELD_BOUND    12'h010
`define OFS_PROG_ADDR      12'h014
`define OFS_PROG_DATA      12'h018
`define OFS_DEBUG_CMD      12'h01c
`define OFS_BREAK_BASE     12'h020

// ****
// option word field positions
// ****
`define OPT_LOCK           0
`define OPT_PWRUP_BOOT     1
`define OPT_ANYRST_BOOT    2
`define OPT_BOOT_LO        3
`define OPT_BOOT_HI        5
`define OPT_BO2_SEL_LO     6
`define OPT_BO2_SEL_HI     8
`define OPT_BO1_RESET      9
`define OPT_BO2_RESET      10
`define OPT_WDT_RESET      11
`define OPT_WDT_NONSTOP    12
`define OPT_WDT_AUTOSTART  13
`define OPT_WDT_IDLE       14
`define OPT_WDT_PS_LO      15
`define OPT_WDT_PS_HI      17
`define OPT_WDT_WPROT      18
`define OPT_FIELD_LO       19
`define OPT_FIELD_HI       26
`define OPT_WIDTH          27

// erased: all off
`define OPT_ERASED         27'h0000000

// ****
// watchdog control field positions
// ****
`define WDT_ENABLE         7
`define WDT_RESET_EN       6
`define WDT_NONSTOP        5
`define WDT_IDLE           4
`define WDT_PS_HI          2

// ****
// addresses and misc values
// ****
`define FLASH_END          16'h1fff
`define MAIN_START         16'h0000
`define LOCKED_BYTE        8'hff
`define DEBUG_CTRL_RESET   8'h01
`define BO2_SEL_2V4        3'b110

`endif

/* design/opt_loader_pkg.sv */
// types shared by the option loader files
// assumes nothing beyond the consts header
package opt_loader_pkg;

   typedef enum logic [2:0] {
      dbg_none   = 3'b000,
      dbg_reset  = 3'b001,
      dbg_run    = 3'b010,
      dbg_stop   = 3'b011,
      dbg_step   = 3'b100,
      dbg_cursor = 3'b101
   } debug_cmd_t;

   typedef enum logic [1:0] {
      ld_idle  = 2'b00,
      ld_load  = 2'b01,
      ld_run   = 2'b10
   } load_state_t;

endpackage

/* design/pin_mux_if.sv */
// bundle between the loader and its debug pin mux
// assumes one clock domain
`timescale 1ns/1ps
interface pin_mux_if;
   logic debug_enable;
   logic halted;
   logic dbg_clk_in;
   logic dbg_data_in;
   modport loader (output debug_enable, output halted, input dbg_clk_in, input dbg_data_in);
   modport mux    (input debug_enable, input halted, output dbg_clk_in, output dbg_data_in);
endinterface

/* design/debug_pin_mux.sv */
// routes p4.4/p4.5 between debug lines and port
// assumes pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
module debug_pin_mux (
   input  wire logic clk,
   input  wire logic rst,
   pin_mux_if.mux    bus,
   input  wire logic pin44_in,
   input  wire logic pin45_in,
   input  wire logic port44_out,
   input  wire logic port44_oe,
   input  wire logic port45_out,
   input  wire logic port45_oe,
   output logic      pin44_out,
   output logic      pin44_oe,
   output logic      pin45_out,
   output logic      pin45_oe,
   output logic      port44_in,
   output logic      port45_in
);
   typedef struct packed {
      logic [1:0] s1;
      logic [1:0] s2;
   } mux_state_t;

   mux_state_t st;
   mux_state_t next_st;

   // ****
   // synchroniser
   // ****
   // second stage reads first only
   always_comb begin
      next_st    = st;
      next_st.s1 = {pin45_in, pin44_in};
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // port drives pins only with debug off
   assign bus.dbg_clk_in  = bus.debug_enable & st.s2[0];
   assign bus.dbg_data_in = bus.debug_enable & st.s2[1];
   assign pin44_out = port44_out;
   assign pin45_out = port45_out;
   // no drive while halted
   assign pin44_oe  = ~bus.debug_enable & ~bus.halted & port44_oe;
   assign pin45_oe  = ~bus.debug_enable & ~bus.halted & port45_oe;
   assign port44_in = st.s2[0];
   assign port45_in = st.s2[1];
endmodule

/* test/debug_adapter_model.sv */
// model of the programming and debug adapter
// assumes tasks called from one process on clk
`timescale 1ns/1ps
module debug_adapter_model (
   input  wire logic clk,
   input  wire logic cpu_halt,
   output logic      adapter_reset,
   output logic      sclk,
   output logic      sdata
);
   // lines idle: clock still, data high
   initial begin
      adapter_reset = 1'b0;
      sclk          = 1'b0;
      sdata         = 1'b1;
   end

   // pulse reset, wait for halt
   task automatic halt_device(output logic ok);
      int i;
      @(posedge clk);
      adapter_reset <= 1'b1;
      repeat (2) @(posedge clk);
      adapter_reset <= 1'b0;
      for (i = 0; i < 20 && cpu_halt !== 1'b1; i++) @(posedge clk);
      ok = cpu_halt;
   endtask

   // one byte msb first, only to a halted core
   task automatic send_frame(input logic [7:0] b);
      int k;
      if (cpu_halt !== 1'b1) return;
      for (k = 7; k >= 0; k--) begin
         @(posedge clk);
         sdata <= b[k];
         sclk  <= 1'b0;
         @(posedge clk);
         sclk  <= 1'b1;
      end
      @(posedge clk);
      sclk  <= 1'b0;
      sdata <= 1'b1; // idle high
   endtask
endmodule

/* test/opt_loader_assertions.sv */
// checks on the loader top ports
// assumes one clock domain; bind at the foot
`timescale 1ns/1ps
module opt_loader_assertions (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        power_on,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        adapter_reset,
   input wire logic        pin44_oe,
   input wire logic        pin45_oe,
   input wire logic        cpu_reset,
   input wire logic        cpu_halt,
   input wire logic [15:0] boot_address,
   input wire logic [15:0] boot_region_start,
   input wire logic        boot_region_valid,
   input wire logic [2:0]  brownout2_threshold,
   input wire logic [7:0]  field_data_lower_boundary
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // pready is tied high: access edge ends a write
   logic wr_done;
   logic cmd_wr;
   assign wr_done = psel && penable && pwrite;
   assign cmd_wr  = wr_done && paddr == 12'h01c;

   chk_reset_release: assert property ($fell(rst) |-> cpu_reset ##1 cpu_reset ##1 !cpu_reset)
      else $error("bad reset release");
   chk_region_shape: assert property (boot_region_valid |-> boot_region_start[8:0] == 9'h000
      && boot_region_start >= 16'h1200 && boot_region_start <= 16'h1e00)
      else $error("bad region start");
   chk_boot_source: assert property (boot_address == 16'h0000 || (boot_address[8:0] == 9'h000
      && boot_address >= 16'h1200 && boot_address <= 16'h1e00))
      else $error("bad boot address");
   chk_threshold_cause: assert property ($changed(brownout2_threshold) |-> $past(wr_done))
      else $error("threshold moved alone");
   chk_bound_cause: assert property ($changed(field_data_lower_boundary) |->
      $past(wr_done) || $past(power_on) || $past(cpu_reset))
      else $error("boundary moved alone");
   chk_halt_entry: assert property ($rose(adapter_reset) |-> ##[1:4] cpu_halt)
      else $error("no halt on reset");
   chk_halt_hold: assert property (cpu_halt && !cmd_wr && !power_on && !cpu_reset |=> cpu_halt)
      else $error("halt left alone");
   chk_step_once: assert property (cpu_halt && cmd_wr && pwdata[2:0] == 3'd4
      |=> !cpu_halt ##1 cpu_halt)
      else $error("bad step");
   chk_pins_halted: assert property (pin44_oe || pin45_oe |-> !cpu_halt)
      else $error("pin driven while halted");

   cover property (cpu_halt && cmd_wr);
   cover property ($fell(cpu_reset));
   cover property (boot_region_valid && pin44_oe);
endmodule

bind hardware_option_loader opt_loader_assertions u_chk (
   .clk, .rst, .power_on, .psel, .penable, .pwrite, .paddr, .pwdata, .adapter_reset,
   .pin44_oe, .pin45_oe, .cpu_reset, .cpu_halt, .boot_address, .boot_region_start,
   .boot_region_valid, .brownout2_threshold, .field_data_lower_boundary
);

/* test/hardware_option_loader_tb.sv */
// self-checking bench for the option loader
// assumes design and adapter model compiled first
`timescale 1ns/1ps
`include "opt_loader_consts.svh"
module hardware_option_loader_tb;
   logic        clk, rst, power_on, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic        adapter_reset, primary_brownout_detector, secondary_brownout_detector;
   logic        watchdog_timeout_flag, pin44_in, pin45_in, port44_out, port44_oe;
   logic        port45_out, port45_oe, pin44_out, pin44_oe, pin45_out, pin45_oe;
   logic        port44_in, port45_in, cpu_reset, cpu_halt, boot_region_valid;
   logic [15:0] cpu_pc, boot_address, boot_region_start;
   logic [2:0]  brownout2_threshold;
   logic [7:0]  watchdog_control_register, field_data_lower_boundary;
   logic [31:0] exp_q[$];
   int          n_fail, n_tests;

   hardware_option_loader #(.BREAKS(4), .FLASH_WORDS(16)) u_dut (
      .clk, .rst, .power_on, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .adapter_reset, .primary_brownout_detector, .secondary_brownout_detector,
      .watchdog_timeout_flag, .cpu_pc, .pin44_in, .pin45_in, .port44_out, .port44_oe,
      .port45_out, .port45_oe, .pin44_out, .pin44_oe, .pin45_out, .pin45_oe, .port44_in,
      .port45_in, .cpu_reset, .cpu_halt, .boot_address, .boot_region_start,
      .boot_region_valid, .brownout2_threshold, .watchdog_control_register,
      .field_data_lower_boundary
   );
   debug_adapter_model u_adapter (
      .clk, .cpu_halt, .adapter_reset, .sclk(pin44_in), .sdata(pin45_in)
   );

   // ****
   // helpers
   // ****
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done;
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask

   // read data taken at the completing edge
   always @(posedge clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
         check(prdata, exp_q.pop_front());
   end

   // wait for a core reset pulse
   task automatic settle;
      int k;
      for (k = 0; k < 20 && cpu_reset !== 1'b1; k++) @(posedge clk);
      for (k = 0; k < 20 && cpu_reset !== 1'b0; k++) @(posedge clk);
   endtask
   task automatic cold_boot;
      @(posedge clk);
      power_on <= 1'b1;
      @(posedge clk);
      power_on <= 1'b0;
      settle();
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      test_done();
   end

   // ****
   // scenarios
   // ****
   initial begin
      logic ok;
      logic [7:0] r;
      logic [2:0] ps;
      int i;
      {rst, power_on, psel, penable, pwrite, port44_out, port44_oe} = 7'h40;
      {primary_brownout_detector, secondary_brownout_detector, watchdog_timeout_flag} = 3'h0;
      {port45_out, port45_oe, paddr, pwdata, cpu_pc} = {2'h0, 12'h0, 32'h0, 16'hffff};
      r = 8'($urandom(32'h7f6ba699));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // erased device
      rd(`OFS_OPTION, 32'h0);
      rd(`OFS_FIELD_BOUND, 32'h0);
      rd(`OFS_DEBUG_CTRL, 32'(`DEBUG_CTRL_RESET));
      check(pin44_oe | pin45_oe, 1'b0);
      u_adapter.halt_device(ok);
      check(ok, 1'b1);
      u_adapter.send_frame(8'($urandom));
      $display("reset done");
      // every boot size code
      for (i = 0; i < 8; i++) begin
         wr(`OFS_OPTION, 32'(i) << `OPT_BOOT_LO);
         @(posedge clk);
         check(boot_region_valid, i != 0);
         if (i != 0) check(boot_region_start, 16'h2000 - 16'(i) * 16'h0200);
      end
      $display("regions done");
      // program, lock
      r = 8'($urandom) & 8'h7f;
      wr(`OFS_OPTION, 32'h0);
      wr(`OFS_PROG_ADDR, 32'h5);
      wr(`OFS_PROG_DATA, {24'h0, r});
      rd(`OFS_PROG_DATA, {24'h0, r});
      wr(`OFS_OPTION, 32'h1 << `OPT_LOCK);
      rd(`OFS_PROG_DATA, {24'h0, `LOCKED_BYTE});
      wr(`OFS_OPTION, 32'(`BO2_SEL_2V4) << `OPT_BO2_SEL_LO);
      @(posedge clk);
      check(brownout2_threshold, `BO2_SEL_2V4);
      r = 8'($urandom);
      wr(`OFS_FIELD_BOUND, {24'h0, r});
      rd(`OFS_FIELD_BOUND, {24'h0, r});
      $display("lock done");
      // watchdog presets, protection
      ps = 3'($urandom);
      wr(`OFS_OPTION, (32'hf << 11) | (32'(ps) << 15) | (32'h1 << 18) | 32'h12);
      cold_boot();
      rd(`OFS_WDT_CTRL, {24'h0, 5'h1e, ps});
      rd(`OFS_STATUS, 32'h1c00);
      wr(`OFS_WDT_CTRL, {24'h0, 8'h80 | ~{5'h1e, ps}});
      rd(`OFS_WDT_CTRL, {24'h0, 5'h1e, ps});
      u_adapter.halt_device(ok);
      wr(`OFS_OPTION, 32'h12);
      r = 8'h80 | (8'($urandom) & 8'h77);
      wr(`OFS_WDT_CTRL, {24'h0, r});
      rd(`OFS_WDT_CTRL, {24'h0, r});
      $display("watchdog done");
      // reset sources
      wr(`OFS_OPTION, 32'h20e);
      wr(`OFS_DEBUG_CMD, {29'h0, opt_loader_pkg::dbg_reset});
      settle();
      rd(`OFS_STATUS, 32'h1e00);
      wr(`OFS_DEBUG_CMD, {29'h0, opt_loader_pkg::dbg_run});
      primary_brownout_detector <= 1'b1;
      repeat (3) @(posedge clk);
      primary_brownout_detector <= 1'b0;
      settle();
      rd(`OFS_STATUS, 32'(`MAIN_START));
      $display("boot done");
      // pin hand-over
      wr(`OFS_DEBUG_CTRL, 32'h0);
      port44_oe  <= 1'b1;
      port44_out <= r[0];
      for (i = 0; i < 20 && pin44_oe !== 1'b1; i++) @(posedge clk);
      check({pin44_oe, pin44_out}, {1'b1, r[0]});
      wr(`OFS_DEBUG_CTRL, 32'h1);
      for (i = 0; i < 20 && pin44_oe !== 1'b0; i++) @(posedge clk);
      check(pin44_oe, 1'b0);
      $display("pins done");
      // breakpoints and debug commands
      for (i = 0; i < 4; i++) wr(12'(`OFS_BREAK_BASE + 4 * i), 32'h10100 + 32'(i));
      cpu_pc <= 16'h0103;
      for (i = 0; i < 20 && cpu_halt !== 1'b1; i++) @(posedge clk);
      rd(`OFS_DEBUG_CMD, 32'h1);
      cpu_pc <= 16'h0200;
      wr(`OFS_DEBUG_CMD, {29'h0, opt_loader_pkg::dbg_step});
      rd(`OFS_DEBUG_CMD, 32'h1);
      wr(`OFS_DEBUG_CMD, {29'h0, opt_loader_pkg::dbg_run});
      wr(`OFS_DEBUG_CMD, {29'h0, opt_loader_pkg::dbg_stop});
      rd(`OFS_DEBUG_CMD, 32'h1);
      wr(`OFS_DEBUG_CMD, {16'h0300, 13'h0, opt_loader_pkg::dbg_cursor});
      rd(`OFS_DEBUG_CMD, 32'h2);
      cpu_pc <= 16'h0300;
      for (i = 0; i < 20 && cpu_halt !== 1'b1; i++) @(posedge clk);
      check(cpu_halt, 1'b1);
      wr(12'h0fc, 32'hffffffff);
      rd(12'h0fc, 32'h0);
      $display("debug done");
      // erase
      wr(`OFS_STATUS, 32'h1);
      rd(`OFS_OPTION, 32'h0);
      check(boot_region_valid, 1'b0);
      $display("erase done");
      test_done();
   end
endmodule
